// File: verilog/ccs_pkg.sv
// Constants, register map and state types of the conversion sequencer.
// Assumes a 125 MHz core clock; all latencies are held in microseconds.
package ccs_pkg;

	// Clock and time base
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned NS_PER_US = 1000;
	localparam int unsigned CYCLES_PER_US_DEF = NS_PER_US / CLK_PERIOD_NS;

	// Register offsets
	localparam logic [7:0] REG_MODE_CONFIG_0 = 8'h00;
	localparam logic [7:0] REG_CONFIG = 8'h04;
	localparam logic [7:0] REG_DELAY = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_COUNT = 8'h10;

	// Field positions
	localparam int MODE_CONV_BIT = 4;
	localparam int CFG_RATE_LSB = 0;
	localparam int CFG_FILT_LSB = 8;
	localparam int CFG_CHOP_LSB = 16;
	localparam int CFG_CRC_BIT = 24;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_RUN_BIT = 1;
	localparam int ST_READY_BIT = 2;
	localparam int ST_START_BIT = 3;

	// Reset values and limits
	localparam logic [15:0] DELAY_DEFAULT_US = 16'h0032;
	localparam logic [4:0] RATE_DEFAULT = 5'h04;
	localparam logic [4:0] RATE_COUNT = 5'h11;
	localparam logic [4:0] RATE_FAST_IDX = 5'h10;
	localparam logic [2:0] FILT_MAX = 3'h5;
	localparam logic [1:0] CHOP_OFF = 2'h0;
	localparam logic [4:0] READY_HOLD_CYC = 5'h10;

	// Serial command framing
	localparam logic [5:0] CMD_BITS_PLAIN = 6'h10;
	localparam logic [5:0] CMD_BITS_CRC = 6'h20;
	localparam logic [5:0] BIT_CNT_MAX = 6'h3f;
	localparam logic [7:0] CMD_START = 8'h08;
	localparam logic [7:0] CMD_STOP = 8'h0a;

	// Synchronised pin positions
	localparam int PIN_START = 0;
	localparam int PIN_SCLK = 1;
	localparam int PIN_SDI = 2;
	localparam int PIN_CS = 3;
	// Pin levels at rest: select and serial clock high
	localparam logic [3:0] PIN_IDLE = 4'ha;

	// Columns: period, FIR, sinc1..sinc5; zero marks an unsupported pairing
	localparam int unsigned LAT_US [17][7] = '{
		'{400000, 402200, 400400, 800400, 1200000, 1600000, 0},
		'{200000, 202200, 200400, 400400, 600400, 800400, 0},
		'{100000, 102200, 100400, 200400, 300400, 400400, 0},
		'{60241, 0, 60430, 120400, 180400, 240400, 0},
		'{50000, 52230, 50430, 100400, 150400, 200400, 0},
		'{20000, 0, 20430, 40430, 60430, 80430, 0},
		'{16667, 0, 17090, 33760, 50430, 67090, 0},
		'{10000, 0, 10430, 20430, 30430, 40430, 0},
		'{2500, 0, 2925, 5425, 7925, 10430, 0},
		'{833, 0, 1258, 2091, 2925, 3758, 0},
		'{417, 0, 841, 1258, 1675, 2091, 0},
		'{208, 0, 633, 841, 1050, 1258, 0},
		'{139, 0, 564, 702, 841, 980, 0},
		'{69, 0, 0, 0, 0, 0, 423},
		'{52, 0, 0, 0, 0, 0, 336},
		'{39, 0, 0, 0, 0, 0, 271},
		'{25, 0, 0, 0, 0, 0, 179}
	};

	typedef enum logic [1:0] {PH_IDLE, PH_DELAY, PH_CONVERT} ccs_phase_e;

	typedef struct packed {
		logic [3:0] syncA;
		logic [3:0] syncB;
		logic [3:0] syncC;
		logic [3:0] pinLvl;
		ccs_phase_e phase;
		logic [31:0] timer;
		logic run;
		logic pulseMode;
		logic [4:0] rate;
		logic [2:0] filt;
		logic [1:0] chop;
		logic crcEn;
		logic [15:0] delayUs;
		logic [5:0] bitCnt;
		logic [31:0] shreg;
		logic readyN;
		logic [4:0] holdCnt;
		logic [31:0] convCount;
		logic [31:0] rdata;
		logic convClkFast;
	} ccs_state_s;

endpackage : ccs_pkg

// File: verilog/ccs_conv_ctrl.sv
// Conversion start/stop sequencer with data-ready output and register port.
// Assumes start, serial clock, data and select pins are asynchronous to core_clk.
//
// Operation
// - Start by pin or serial start command
// - Command acts at 16th/32nd falling serial edge
// - Mode register bit 4 selects pulse/continuous
// - Continuous mode converts back to back indefinitely
// - Continuous starts on pin high or command
// - Ready output high at start, low when done
// - Continuous stop lets current conversion finish
// - Pin retoggle or start command restarts conversion
// - Pulse mode makes exactly one conversion
// - Pulse mode stop never aborts conversion
// - FIR and sinc1 settle in one cycle
// - First latency includes delay and overhead
// - Later results follow one data period apart
// - Chop doubles first latency, then latency period
// - Latencies at 2.5 samples per second
// - Latencies at 20 samples per second
// - Latencies at 60 samples per second
// - Latencies at 7200 samples per second
// - Programmable delay precedes each started conversion
// - Fast conversion clock only at top rate
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none

module ccs_conv_ctrl
	import ccs_pkg::*;
#(
	parameter int unsigned CYCLES_PER_US = CYCLES_PER_US_DEF
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic startPin,
	input wire logic sclkPin,
	input wire logic sdiPin,
	input wire logic csPinN,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdata,
	output logic resultReadyN,
	output logic convClkFast
);

	ccs_state_s st;
	ccs_state_s next_st;

	logic [3:0] agree;
	logic [3:0] newLvl;
	logic [3:0] rise;
	logic [3:0] fall;
	logic [31:0] shifted;
	logic [7:0] opcode;
	logic cmdFire;
	logic startEv;
	logic stopEv;
	logic [31:0] latUs;
	logic [31:0] firstRemUs;
	logic [31:0] nextUs;
	logic [31:0] statusWord;

	// Microseconds to core clock cycles, never below one
	function automatic logic [31:0] us2cyc(input logic [31:0] us);
		logic [63:0] prod;
		prod = 64'(us) * 64'(CYCLES_PER_US);
		if (prod[31:0] == 32'h0) begin
			return 32'h1;
		end
		return prod[31:0];
	endfunction : us2cyc

	// Table latency for rate and filter, falling back to the period
	function automatic logic [31:0] lookupLat(input logic [4:0] rate, input logic [2:0] filt);
		int unsigned v;
		v = LAT_US[rate][filt + 3'h1];
		if (v == 0) begin
			v = LAT_US[rate][0];
		end
		return 32'(v);
	endfunction : lookupLat

	// Time left once the built-in start delay is taken off, never negative
	function automatic logic [31:0] afterDelay(input logic [31:0] us);
		if (us <= 32'(DELAY_DEFAULT_US)) begin
			return 32'h0;
		end
		return us - 32'(DELAY_DEFAULT_US);
	endfunction : afterDelay

	always_comb begin
		// Level changes only once stages two and three agree
		agree = ~(st.syncB ^ st.syncC);
		newLvl = (agree & st.syncC) | (~agree & st.pinLvl);
		rise = newLvl & ~st.pinLvl;
		fall = ~newLvl & st.pinLvl;

		// Command byte leads the frame; sampled on falling serial edges
		shifted = {st.shreg[30:0], newLvl[PIN_SDI]};
		opcode = st.crcEn ? shifted[31:24] : shifted[15:8];
		cmdFire = fall[PIN_SCLK] && !newLvl[PIN_CS]
			&& ((st.bitCnt + 6'h1) == (st.crcEn ? CMD_BITS_CRC : CMD_BITS_PLAIN));

		// Pin and command controls merge into one event stream
		startEv = rise[PIN_START] || (cmdFire && opcode == CMD_START);
		stopEv = fall[PIN_START] || (cmdFire && opcode == CMD_STOP);

		// Latency figures per rate, filter and chop setting
		latUs = lookupLat(st.rate, st.filt);
		if (st.chop != CHOP_OFF) begin
			firstRemUs = afterDelay(latUs << 1);
			nextUs = latUs;
		end else begin
			firstRemUs = afterDelay(latUs);
			nextUs = LAT_US[st.rate][0];
		end

		statusWord = '0;
		statusWord[ST_BUSY_BIT] = st.phase != PH_IDLE;
		statusWord[ST_RUN_BIT] = st.run;
		statusWord[ST_READY_BIT] = !st.readyN;
		statusWord[ST_START_BIT] = st.pinLvl[PIN_START];
	end

	always_comb begin
		next_st = st;
		next_st.syncA = {csPinN, sdiPin, sclkPin, startPin};
		next_st.syncB = st.syncA;
		next_st.syncC = st.syncB;
		next_st.pinLvl = newLvl;

		// Serial framing: select high clears the edge count
		if (newLvl[PIN_CS]) begin
			next_st.bitCnt = '0;
		end else if (fall[PIN_SCLK] && st.bitCnt != BIT_CNT_MAX) begin
			next_st.bitCnt = st.bitCnt + 6'h1;
			next_st.shreg = shifted;
		end

		// Register writes
		if (regWrite) begin
			case (regAddr)
				REG_MODE_CONFIG_0: begin
					next_st.pulseMode = regWdata[MODE_CONV_BIT];
				end
				REG_CONFIG: begin
					if (regWdata[CFG_RATE_LSB +: 5] < RATE_COUNT) begin
						next_st.rate = regWdata[CFG_RATE_LSB +: 5];
					end
					if (regWdata[CFG_FILT_LSB +: 3] <= FILT_MAX) begin
						next_st.filt = regWdata[CFG_FILT_LSB +: 3];
					end
					next_st.chop = regWdata[CFG_CHOP_LSB +: 2];
					next_st.crcEn = regWdata[CFG_CRC_BIT];
				end
				REG_DELAY: begin
					next_st.delayUs = regWdata[15:0];
				end
				default: begin
				end
			endcase
		end

		// Read data stands only in the cycle after the strobe
		next_st.rdata = '0;
		if (regRead) begin
			case (regAddr)
				REG_MODE_CONFIG_0: next_st.rdata[MODE_CONV_BIT] = st.pulseMode;
				REG_CONFIG: begin
					next_st.rdata[CFG_RATE_LSB +: 5] = st.rate;
					next_st.rdata[CFG_FILT_LSB +: 3] = st.filt;
					next_st.rdata[CFG_CHOP_LSB +: 2] = st.chop;
					next_st.rdata[CFG_CRC_BIT] = st.crcEn;
				end
				REG_DELAY: next_st.rdata[15:0] = st.delayUs;
				REG_STATUS: next_st.rdata = statusWord;
				REG_COUNT: next_st.rdata = st.convCount;
				default: next_st.rdata = '0;
			endcase
		end

		// Ready output returns high 16 cycles after a continuous-mode result, while the follow-on conversion runs
		if (st.holdCnt != '0) begin
			next_st.holdCnt = st.holdCnt - 5'h1;
			if (st.holdCnt == 5'h1) begin
				next_st.readyN = 1'b1;
			end
		end

		// Conversion sequencing
		if (startEv) begin
			next_st.phase = PH_DELAY;
			next_st.timer = us2cyc(32'(st.delayUs));
			next_st.readyN = 1'b1;
			next_st.holdCnt = '0;
			next_st.run = !st.pulseMode;
		end else begin
			if (stopEv) begin
				next_st.run = 1'b0;
			end
			case (st.phase)
				PH_IDLE: begin
				end
				PH_DELAY: begin
					if (st.timer == 32'h1) begin
						next_st.phase = PH_CONVERT;
						next_st.timer = us2cyc(firstRemUs);
					end else begin
						next_st.timer = st.timer - 32'h1;
					end
				end
				PH_CONVERT: begin
					if (st.timer == 32'h1) begin
						next_st.readyN = 1'b0;
						next_st.convCount = st.convCount + 32'h1;
						if (next_st.run && !st.pulseMode) begin
							next_st.timer = us2cyc(nextUs);
							next_st.holdCnt = READY_HOLD_CYC;
						end else begin
							next_st.phase = PH_IDLE;
						end
					end else begin
						next_st.timer = st.timer - 32'h1;
					end
				end
				default: begin
					next_st.phase = PH_IDLE;
				end
			endcase
		end

		next_st.convClkFast = next_st.rate == RATE_FAST_IDX;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			st <= '0;
			st.readyN <= 1'b1;
			st.delayUs <= DELAY_DEFAULT_US;
			st.rate <= RATE_DEFAULT;
			// Idle levels avoid a false edge right after reset
			st.syncA <= PIN_IDLE;
			st.syncB <= PIN_IDLE;
			st.syncC <= PIN_IDLE;
			st.pinLvl <= PIN_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign regRdata = st.rdata;
	assign resultReadyN = st.readyN;
	assign convClkFast = st.convClkFast;

	// Checks
	logic agreeStart;
	logic endConvert;
	assign agreeStart = agree[PIN_START];
	assign endConvert = st.phase == PH_CONVERT && st.timer == 32'h1 && !startEv;

	property p_ready_rise;
		@(posedge core_clk) disable iff (reset)
		startEv |=> resultReadyN;
	endproperty
	a_ready_rise: assert property (p_ready_rise) else $error("ready not high at start");

	property p_ready_fall;
		@(posedge core_clk) disable iff (reset)
		endConvert |=> !resultReadyN && st.convCount == $past(st.convCount) + 32'h1;
	endproperty
	a_ready_fall: assert property (p_ready_fall) else $error("ready not low at end");

	property p_cmd_edge;
		@(posedge core_clk) disable iff (reset)
		cmdFire |-> fall[PIN_SCLK] && (st.crcEn ? st.bitCnt == 6'h1f : st.bitCnt == 6'h0f);
	endproperty
	a_cmd_edge: assert property (p_cmd_edge) else $error("command on wrong edge");

	property p_restart;
		@(posedge core_clk) disable iff (reset)
		startEv |=> st.phase == PH_DELAY && st.timer == us2cyc(32'($past(st.delayUs)));
	endproperty
	a_restart: assert property (p_restart) else $error("start did not restart");

	property p_pulse_end;
		@(posedge core_clk) disable iff (reset)
		(endConvert && st.pulseMode) |=> st.phase == PH_IDLE ##1 (st.phase == PH_IDLE || $past(startEv));
	endproperty
	a_pulse_end: assert property (p_pulse_end) else $error("pulse mode went on");

	property p_stop_finish;
		@(posedge core_clk) disable iff (reset)
		(stopEv && !startEv && st.phase == PH_CONVERT && st.timer > 32'h1)
			|=> st.phase == PH_CONVERT && st.timer == $past(st.timer) - 32'h1;
	endproperty
	a_stop_finish: assert property (p_stop_finish) else $error("stop aborted conversion");

	property p_cont_next;
		@(posedge core_clk) disable iff (reset)
		(endConvert && st.run && !st.pulseMode && !stopEv)
			|=> st.phase == PH_CONVERT && st.timer == us2cyc($past(nextUs));
	endproperty
	a_cont_next: assert property (p_cont_next) else $error("next period wrong");

	property p_first;
		@(posedge core_clk) disable iff (reset)
		(st.phase == PH_DELAY && st.timer == 32'h1 && !startEv)
			|=> st.phase == PH_CONVERT && st.timer == us2cyc($past(firstRemUs));
	endproperty
	a_first: assert property (p_first) else $error("first latency wrong");

	property p_sync;
		@(posedge core_clk) disable iff (reset)
		$changed(st.pinLvl[PIN_START]) |-> $past(agreeStart);
	endproperty
	a_sync: assert property (p_sync) else $error("start level moved early");

	property p_clk_sel;
		@(posedge core_clk) disable iff (reset)
		(regWrite && regAddr == REG_CONFIG && regWdata[CFG_RATE_LSB +: 5] == RATE_FAST_IDX)
			|=> convClkFast [*2];
	endproperty
	a_clk_sel: assert property (p_clk_sel) else $error("fast clock not selected");

	property p_fast_off;
		@(posedge core_clk) disable iff (reset)
		(regWrite && regAddr == REG_CONFIG && regWdata[CFG_RATE_LSB +: 5] < RATE_FAST_IDX) |=> !convClkFast;
	endproperty
	a_fast_off: assert property (p_fast_off) else $error("fast clock left on");

	property p_ready_hold;
		@(posedge core_clk) disable iff (reset)
		(st.holdCnt == 5'h1 && !endConvert && !startEv) |=> resultReadyN;
	endproperty
	a_ready_hold: assert property (p_ready_hold) else $error("ready not released after hold");

	property p_delay_ready;
		@(posedge core_clk) disable iff (reset)
		st.phase == PH_DELAY |-> resultReadyN;
	endproperty
	a_delay_ready: assert property (p_delay_ready) else $error("ready low during start delay");

	property p_idle_stay;
		@(posedge core_clk) disable iff (reset)
		(st.phase == PH_IDLE && !startEv) |=> st.phase == PH_IDLE;
	endproperty
	a_idle_stay: assert property (p_idle_stay) else $error("conversion without start");

	property p_stop_run;
		@(posedge core_clk) disable iff (reset)
		(stopEv && !startEv) |=> !st.run;
	endproperty
	a_stop_run: assert property (p_stop_run) else $error("stop did not halt run");

	property p_pulse_once;
		@(posedge core_clk) disable iff (reset)
		(startEv && st.pulseMode) |=> !st.run;
	endproperty
	a_pulse_once: assert property (p_pulse_once) else $error("pulse start set run");

	property p_cont_run;
		@(posedge core_clk) disable iff (reset)
		(startEv && !st.pulseMode) |=> st.run;
	endproperty
	a_cont_run: assert property (p_cont_run) else $error("continuous start did not run");

	property p_delay_count;
		@(posedge core_clk) disable iff (reset)
		(st.phase == PH_DELAY && st.timer > 32'h1 && !startEv)
			|=> st.phase == PH_DELAY && st.timer == $past(st.timer) - 32'h1;
	endproperty
	a_delay_count: assert property (p_delay_count) else $error("start delay miscounted");

endmodule : ccs_conv_ctrl

`default_nettype wire

// File: test/ccs_host_model.sv
// Host model: start pin and serial command frames.
// Assumes core_clk from the bench; serial clock idles high outside frames.
`timescale 1ns/10ps
`default_nettype none
module ccs_host_model
	import ccs_pkg::*;
(
	input wire logic core_clk,
	output var logic startPin,
	output var logic sclkPin,
	output var logic sdiPin,
	output var logic csPinN
);
	initial begin
		startPin = 1'b0;
		sclkPin = 1'b1;
		sdiPin = 1'b0;
		csPinN = 1'b1;
	end
	task automatic set_start(input logic v);
		@(posedge core_clk);
		startPin <= v;
	endtask : set_start
	// Opcode in the top byte, filler next; 16 bits, or 32 with CRC
	task automatic send_cmd(input logic [7:0] op, input logic crc, input logic [7:0] pad);
		logic [31:0] fr;
		int n;
		fr = {op, pad, 16'h0};
		n = crc ? 32 : 16;
		csPinN = 1'b0;
		#62.5;
		for (int i = 0; i < n; i++) begin
			sdiPin = fr[31 - i];
			#62.5 sclkPin = 1'b0;
			#62.5 sclkPin = 1'b1;
		end
		#62.5 csPinN = 1'b1;
		sdiPin = ~sdiPin;
		#125;
	endtask : send_cmd
endmodule : ccs_host_model
`default_nettype wire

// File: test/ccs_conv_ctrl_bench.sv
// Bench of the conversion sequencer, one cycle per microsecond.
// Assumes the host model drives the pins; intervals measured on the ready output.
`timescale 1ns/10ps
`default_nettype none
module ccs_conv_ctrl_bench
	import ccs_pkg::*;
;
	logic core_clk, reset, regWrite, regRead, resultReadyN, convClkFast, rdPend, prevN;
	logic prevPin;
	logic firstRef = 1'b1;
	logic startPin, sclkPin, sdiPin, csPinN;
	logic [7:0] regAddr;
	logic [31:0] regWdata, regRdata, lfsr;
	int n_mismatch, compares, cyc, tRef, tFall, dly;
	logic [31:0] rdq[$];
	int latq[$];
	int lat7200[4] = '{564, 702, 841, 980};
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	ccs_conv_ctrl #(.CYCLES_PER_US(1)) uut (.core_clk(core_clk), .reset(reset),
		.startPin(startPin), .sclkPin(sclkPin), .sdiPin(sdiPin), .csPinN(csPinN),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .resultReadyN(resultReadyN), .convClkFast(convClkFast));
	ccs_host_model host (.core_clk(core_clk), .startPin(startPin), .sclkPin(sclkPin),
		.sdiPin(sdiPin), .csPinN(csPinN));
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_lat(input int got, input int exp);
		compares++;
		if (got != exp) begin
			n_mismatch++;
			$display("[FAIL] %0t interval %0d expected %0d", $time, got, exp);
		end
	endtask : chk_lat
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		regAddr <= a;
		regRead <= 1'b1;
		rdq.push_back(e);
		@(posedge core_clk);
		regRead <= 1'b0;
	endtask : rd
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask : idle
	task automatic drain;
		for (int i = 0; i < 20000 && latq.size() > 0; i++) @(posedge core_clk);
		if (latq.size() > 0) begin
			n_mismatch++;
			$display("[FAIL] %0t result missing", $time);
		end
	endtask : drain
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr_next
	task automatic set_dly;
		lfsr = lfsr_next(lfsr);
		dly = 50 + int'(lfsr[4:0]);
		wr(REG_DELAY, 32'(dly));
	endtask : set_dly
	task automatic wrap_up;
		$display("Counts: %0d mismatches, %0d compares", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	always @(posedge core_clk) begin
		if (rdPend)
			chk_reg(regRdata, rdq.pop_front());
		rdPend <= regRead;
	end
	// Reference is the rise, or the last fall after a 16-cycle hold
	always @(posedge core_clk) begin
		cyc++;
		// First start after reset finds ready already high: the pin edge stands in
		if (!reset && firstRef && prevPin === 1'b0 && startPin === 1'b1)
			tRef = cyc + 4;
		if (!reset && prevN === 1'b0 && resultReadyN === 1'b1)
			tRef = (cyc - tFall == 16) ? tFall : cyc;
		if (!reset && prevN === 1'b1 && resultReadyN === 1'b0) begin
			if (latq.size() == 0) begin
				n_mismatch++;
				$display("[FAIL] %0t unexpected result", $time);
			end else
				chk_lat(cyc - tRef, latq.pop_front());
			tFall = cyc;
			firstRef = 1'b0;
		end
		prevN = resultReadyN;
		prevPin = startPin;
	end
	initial begin
		#600000;
		n_mismatch++;
		$display("[FAIL] %0t watchdog expired", $time);
		wrap_up();
	end
	initial begin
		{reset, rdPend, prevN} = 3'b101;
		{regAddr, regWdata, regWrite, regRead} = '0;
		lfsr = 32'hfc49;
		{n_mismatch, compares, cyc, tRef} = '0;
		tFall = -100;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		rd(REG_MODE_CONFIG_0, 32'h0);
		rd(REG_CONFIG, 32'h4);
		rd(REG_DELAY, 32'h32);
		rd({3'h7, lfsr[4:0]}, 32'h0);
		wr(REG_CONFIG, 32'h11);
		rd(REG_CONFIG, 32'h4);
		wr(REG_CONFIG, 32'h10);
		idle(3);
		chk_reg({31'h0, convClkFast}, 32'h1);
		for (int f = 1; f <= 4; f++) begin
			wr(REG_CONFIG, 32'(f << 8) | 32'hc);
			set_dly;
			latq.push_back(dly + lat7200[f - 1] - 50);
			latq.push_back(139);
			latq.push_back(139);
			host.set_start(1'b1);
			drain;
			latq.push_back(139);
			host.set_start(1'b0);
			drain;
			idle(300);
		end
		chk_reg({31'h0, convClkFast}, 32'h0);
		wr(REG_CONFIG, 32'h1010c);
		set_dly;
		latq.push_back(dly + 2 * 564 - 50);
		latq.push_back(564);
		host.send_cmd(CMD_START, 1'b0, lfsr[15:8]);
		drain;
		latq.push_back(564);
		host.send_cmd(CMD_STOP, 1'b0, lfsr[23:16]);
		drain;
		idle(700);
		wr(REG_MODE_CONFIG_0, lfsr | 32'h10);
		rd(REG_MODE_CONFIG_0, 32'h10);
		wr(REG_CONFIG, 32'h10c);
		set_dly;
		latq.push_back(dly + 514);
		host.send_cmd(CMD_START, 1'b0, lfsr[15:8]);
		host.send_cmd(CMD_STOP, 1'b0, lfsr[23:16]);
		drain;
		idle(800);
		wr(REG_CONFIG, 32'h100010c);
		host.send_cmd(CMD_START, 1'b0, lfsr[15:8]);
		idle(20);
		chk_reg({31'h0, resultReadyN}, 32'h0);
		set_dly;
		latq.push_back(dly + 514);
		host.send_cmd(CMD_START, 1'b1, lfsr[15:8]);
		drain;
		set_dly;
		latq.push_back(110 + dly + 514);
		host.set_start(1'b1);
		idle(99);
		host.set_start(1'b0);
		idle(9);
		host.set_start(1'b1);
		drain;
		host.set_start(1'b0);
		wr(REG_CONFIG, 32'h106);
		set_dly;
		latq.push_back(dly + 17090 - 50);
		host.send_cmd(CMD_START, 1'b0, lfsr[15:8]);
		drain;
		idle(800);
		wrap_up();
	end
endmodule : ccs_conv_ctrl_bench
`default_nettype wire
